// *** rac_regbank.sv ***
// Register bank with read/write, read-only, write-only and set/clear alias registers
`timescale 1ns/10ps

// Functional notes
// - Read/write bits read back what was stored; a same-cycle port 0 write beats port 1, and a soft reset beats both except on the debug control register.
// - Read-only bits show live state; writes to them change nothing.
// - Write-only bits accept writes; their read value is not checked.
// - Reserved bit positions always read as zero.
// - A read-only multi-bit field never shows a reserved encoding.
// - Registers return to reset values on power-on; all but debug control also return to them on peripheral soft reset.
// - Debug control registers keep their value across a peripheral soft reset.
// - A one written to the clear alias clears that shared bit.
// - A one written to the set alias sets that shared bit.
// - Both aliases of a pair read the same shared value.
// - Simultaneous set and clear of one bit: clear wins.
module rac_regbank (
  input  wire logic                       clk_in,
  input  wire logic                       rst_b_in,
  input  wire logic                       wr0_en_in,
  input  wire logic [rac_pkg::RAC_AW-1:0] wr0_addr_in,
  input  wire logic [rac_pkg::RAC_DW-1:0] wr0_data_in,
  input  wire logic                       wr1_en_in,
  input  wire logic [rac_pkg::RAC_AW-1:0] wr1_addr_in,
  input  wire logic [rac_pkg::RAC_DW-1:0] wr1_data_in,
  input  wire logic                       rd_en_in,
  input  wire logic [rac_pkg::RAC_AW-1:0] rd_addr_in,
  input  wire logic                       busy_in,
  output logic      [rac_pkg::RAC_DW-1:0] rdata_out,
  output logic                            enable_out,
  output logic      [1:0]                 mode_out,
  output logic      [rac_pkg::RAC_DW-1:0] flags_out,
  output logic      [rac_pkg::RAC_DW-1:0] dbg_out,
  output logic                            cmd_pulse_out
);

  rac_pkg::rac_state_t st_r;
  rac_pkg::rac_state_t st_nxt;

  logic                       we    [2];
  logic [rac_pkg::RAC_AW-1:0] wa    [2];
  logic [rac_pkg::RAC_DW-1:0] wd    [2];
  logic [rac_pkg::RAC_DW-1:0] set_m;
  logic [rac_pkg::RAC_DW-1:0] clr_m;
  logic                       srst;
  rac_pkg::rac_mode_t         mode;
  logic [rac_pkg::RAC_DW-1:0] status;
  logic [rac_pkg::RAC_DW-1:0] rd_mux;
  logic                       pulse_req;

  assign we[0] = wr0_en_in;
  assign wa[0] = wr0_addr_in;
  assign wd[0] = wr0_data_in;
  assign we[1] = wr1_en_in;
  assign wa[1] = wr1_addr_in;
  assign wd[1] = wr1_data_in;

  // Masks, decode and status packing assume byte registers at eight offsets
  if (rac_pkg::RAC_DW != 8) begin : g_dw_chk
    $error("rac_regbank: register width must be 8");
  end
  if (rac_pkg::RAC_AW != 3) begin : g_aw_chk
    $error("rac_regbank: offset width must be 3");
  end

  // Reserved mode code from a misbehaving writer falls back to idle
  always_comb begin
    case (st_r.ctrl[rac_pkg::RAC_CTRL_MODE_LSB +: 2])
      2'b00:   mode = rac_pkg::RAC_MODE_IDLE;
      2'b01:   mode = rac_pkg::RAC_MODE_RUN;
      2'b10:   mode = rac_pkg::RAC_MODE_HOLD;
      default: mode = rac_pkg::RAC_MODE_IDLE;
    endcase
  end

  always_comb begin
    status = 8'h00;
    status[rac_pkg::RAC_STAT_EN_BIT] = st_r.ctrl[rac_pkg::RAC_CTRL_EN_BIT];
    status[rac_pkg::RAC_STAT_STATE_LSB +: 2] = mode;
    status[rac_pkg::RAC_STAT_BUSY_BIT] = busy_in;
  end

  always_comb begin
    case (rd_addr_in)
      rac_pkg::RAC_CTRL_OFS:    rd_mux = st_r.ctrl;
      rac_pkg::RAC_STATUS_OFS:  rd_mux = status;
      rac_pkg::RAC_FLAGSET_OFS: rd_mux = st_r.flags;
      rac_pkg::RAC_FLAGCLR_OFS: rd_mux = st_r.flags;
      rac_pkg::RAC_DBG_OFS:     rd_mux = st_r.dbg;
      // Write-only command and unmapped offsets read zero
      default:                  rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.cmd_pulse = 1'b0;
    set_m = 8'h00;
    clr_m = 8'h00;
    srst = 1'b0;
    // Port 1 first so port 0 wins on a plain register both ports hit
    for (int p = 1; p >= 0; p--) begin
      if (we[p]) begin
        case (wa[p])
          // Reserved bits are dropped, never stored
          rac_pkg::RAC_CTRL_OFS: st_nxt.ctrl = wd[p] & rac_pkg::RAC_CTRL_RW_MASK;
          rac_pkg::RAC_DBG_OFS:  st_nxt.dbg = wd[p] & rac_pkg::RAC_DBG_RW_MASK;
          rac_pkg::RAC_CMD_OFS: begin
            if (wd[p][rac_pkg::RAC_CMD_PULSE_BIT]) begin
              st_nxt.cmd_pulse = 1'b1;
            end
            if (wd[p][rac_pkg::RAC_CMD_SWRST_BIT]) begin
              srst = 1'b1;
            end
          end
          rac_pkg::RAC_FLAGSET_OFS: set_m = set_m | wd[p];
          rac_pkg::RAC_FLAGCLR_OFS: clr_m = clr_m | wd[p];
          // Status is read-only: nothing stored
          default: ;
        endcase
      end
    end
    // Clear applied last so it beats a set of the same bit
    st_nxt.flags = (st_r.flags | set_m) & ~clr_m;
    if (srst) begin
      st_nxt.ctrl = rac_pkg::RAC_CTRL_RST;
      st_nxt.flags = rac_pkg::RAC_FLAGS_RST;
      st_nxt.cmd_pulse = 1'b0;
      // Debug control deliberately left as is
    end
    if (rd_en_in) begin
      st_nxt.rdata = rd_mux;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      st_r <= rac_pkg::RAC_STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata_out = st_r.rdata;
  assign enable_out = st_r.ctrl[rac_pkg::RAC_CTRL_EN_BIT];
  assign mode_out = mode;
  assign flags_out = st_r.flags;
  assign dbg_out = st_r.dbg;
  assign cmd_pulse_out = st_r.cmd_pulse;

  // Assertion helper: any command write that asks for the pulse
  assign pulse_req = (wr0_en_in && (wr0_addr_in == rac_pkg::RAC_CMD_OFS)
                      && wr0_data_in[rac_pkg::RAC_CMD_PULSE_BIT])
                     || (wr1_en_in && (wr1_addr_in == rac_pkg::RAC_CMD_OFS)
                         && wr1_data_in[rac_pkg::RAC_CMD_PULSE_BIT]);

  sequence s_swrst_req;
    wr0_en_in && (wr0_addr_in == rac_pkg::RAC_CMD_OFS)
      && wr0_data_in[rac_pkg::RAC_CMD_SWRST_BIT] && !wr1_en_in;
  endsequence

  sequence s_set_clr_same;
    wr0_en_in && (wr0_addr_in == rac_pkg::RAC_FLAGSET_OFS)
      && wr1_en_in && (wr1_addr_in == rac_pkg::RAC_FLAGCLR_OFS);
  endsequence

  sequence s_clr_set_swapped;
    wr1_en_in && (wr1_addr_in == rac_pkg::RAC_FLAGSET_OFS)
      && wr0_en_in && (wr0_addr_in == rac_pkg::RAC_FLAGCLR_OFS);
  endsequence

  sequence s_pulse_req;
    wr0_en_in && (wr0_addr_in == rac_pkg::RAC_CMD_OFS)
      && wr0_data_in[rac_pkg::RAC_CMD_PULSE_BIT] && !srst;
  endsequence

  property p_rw_store;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr0_en_in && (wr0_addr_in == rac_pkg::RAC_CTRL_OFS) && !srst)
      |=> (st_r.ctrl == ($past(wr0_data_in) & rac_pkg::RAC_CTRL_RW_MASK));
  endproperty
  a_rw_store: assert property (p_rw_store) else $error("ctrl write not stored");

  property p_rw_read;
    @(posedge clk_in) disable iff (!rst_b_in)
    (rd_en_in && (rd_addr_in == rac_pkg::RAC_CTRL_OFS)) |=> (rdata_out == $past(st_r.ctrl));
  endproperty
  a_rw_read: assert property (p_rw_read) else $error("ctrl read mismatch");

  property p_ro_ignore;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr0_en_in && (wr0_addr_in == rac_pkg::RAC_STATUS_OFS) && !wr1_en_in)
      |=> ($stable(st_r.ctrl) && $stable(st_r.flags) && $stable(st_r.dbg));
  endproperty
  a_ro_ignore: assert property (p_ro_ignore) else $error("status write changed state");

  property p_ro_read;
    @(posedge clk_in) disable iff (!rst_b_in)
    (rd_en_in && (rd_addr_in == rac_pkg::RAC_STATUS_OFS))
      |=> (rdata_out == {4'h0, $past(busy_in), $past(mode_out), $past(enable_out)});
  endproperty
  a_ro_read: assert property (p_ro_read) else $error("status read mismatch");

  property p_wo_pulse;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_pulse_req |=> cmd_pulse_out;
  endproperty
  a_wo_pulse: assert property (p_wo_pulse) else $error("command pulse missing");

  // Pulse lasts one cycle unless a new request follows at once
  property p_pulse_single;
    @(posedge clk_in) disable iff (!rst_b_in)
    !pulse_req |=> !cmd_pulse_out;
  endproperty
  a_pulse_single: assert property (p_pulse_single) else $error("stray command pulse");

  property p_resv_zero;
    @(posedge clk_in) disable iff (!rst_b_in)
    (st_r.ctrl[7:3] == 5'h00) && (st_r.dbg[7:2] == 6'h00) && (status[7:4] == 4'h0);
  endproperty
  a_resv_zero: assert property (p_resv_zero) else $error("reserved bit reads nonzero");

  property p_mode_defined;
    @(posedge clk_in) disable iff (!rst_b_in)
    mode_out != 2'b11;
  endproperty
  a_mode_defined: assert property (p_mode_defined) else $error("reserved mode code shown");

  property p_swrst;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_swrst_req |=> (st_r.ctrl == rac_pkg::RAC_CTRL_RST)
      && (st_r.flags == rac_pkg::RAC_FLAGS_RST);
  endproperty
  a_swrst: assert property (p_swrst) else $error("soft reset did not restore");

  property p_dbg_kept;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_swrst_req |=> (st_r.dbg == $past(st_r.dbg));
  endproperty
  a_dbg_kept: assert property (p_dbg_kept) else $error("soft reset touched debug");

  property p_clr;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr0_en_in && (wr0_addr_in == rac_pkg::RAC_FLAGCLR_OFS))
      |=> ((st_r.flags & $past(wr0_data_in)) == 8'h00);
  endproperty
  a_clr: assert property (p_clr) else $error("clear alias did not clear");

  property p_set;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr0_en_in && (wr0_addr_in == rac_pkg::RAC_FLAGSET_OFS) && !wr1_en_in)
      |=> ((st_r.flags & $past(wr0_data_in)) == $past(wr0_data_in));
  endproperty
  a_set: assert property (p_set) else $error("set alias did not set");

  property p_pair_read;
    @(posedge clk_in) disable iff (!rst_b_in)
    (rd_en_in && ((rd_addr_in == rac_pkg::RAC_FLAGSET_OFS)
      || (rd_addr_in == rac_pkg::RAC_FLAGCLR_OFS))) |=> (rdata_out == $past(flags_out));
  endproperty
  a_pair_read: assert property (p_pair_read) else $error("alias reads differ");

  property p_clr_wins;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_set_clr_same |=> ((st_r.flags & $past(wr1_data_in)) == 8'h00);
  endproperty
  a_clr_wins: assert property (p_clr_wins) else $error("set beat clear");

  property p_zero_keep;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr0_en_in && ((wr0_addr_in == rac_pkg::RAC_FLAGSET_OFS)
      || (wr0_addr_in == rac_pkg::RAC_FLAGCLR_OFS)) && !wr1_en_in)
      |=> ((st_r.flags & ~$past(wr0_data_in)) == ($past(flags_out) & ~$past(wr0_data_in)));
  endproperty
  a_zero_keep: assert property (p_zero_keep) else $error("zero write changed a flag");

  property p_por;
    @(posedge clk_in)
    !rst_b_in |=> (st_r == rac_pkg::RAC_STATE_RST);
  endproperty
  a_por: assert property (p_por) else $error("reset value not restored");

  property p_dbg_store;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr0_en_in && (wr0_addr_in == rac_pkg::RAC_DBG_OFS))
      |=> (st_r.dbg == ($past(wr0_data_in) & rac_pkg::RAC_DBG_RW_MASK));
  endproperty
  a_dbg_store: assert property (p_dbg_store) else $error("debug write not stored");

  property p_ro_ignore1;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr1_en_in && (wr1_addr_in == rac_pkg::RAC_STATUS_OFS) && !wr0_en_in)
      |=> ($stable(st_r.ctrl) && $stable(st_r.flags) && $stable(st_r.dbg));
  endproperty
  a_ro_ignore1: assert property (p_ro_ignore1) else $error("port 1 status write changed state");

  property p_clr1;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr1_en_in && (wr1_addr_in == rac_pkg::RAC_FLAGCLR_OFS))
      |=> ((st_r.flags & $past(wr1_data_in)) == 8'h00);
  endproperty
  a_clr1: assert property (p_clr1) else $error("port 1 clear did not clear");

  property p_set1;
    @(posedge clk_in) disable iff (!rst_b_in)
    (wr1_en_in && (wr1_addr_in == rac_pkg::RAC_FLAGSET_OFS) && !wr0_en_in)
      |=> ((st_r.flags & $past(wr1_data_in)) == $past(wr1_data_in));
  endproperty
  a_set1: assert property (p_set1) else $error("port 1 set did not set");

  property p_clr_wins1;
    @(posedge clk_in) disable iff (!rst_b_in)
    s_clr_set_swapped |=> ((st_r.flags & $past(wr0_data_in)) == 8'h00);
  endproperty
  a_clr_wins1: assert property (p_clr_wins1) else $error("set beat clear on port 1");

endmodule // rac_regbank

// *** rac_pkg.sv ***
// Register access conventions: offsets, field layout, reset values and types
package rac_pkg;

  localparam int RAC_AW = 3;
  localparam int RAC_DW = 8;

  // Register offsets
  localparam logic [2:0] RAC_CTRL_OFS    = 3'h0;
  localparam logic [2:0] RAC_STATUS_OFS  = 3'h1;
  localparam logic [2:0] RAC_CMD_OFS     = 3'h2;
  localparam logic [2:0] RAC_FLAGSET_OFS = 3'h3;
  localparam logic [2:0] RAC_FLAGCLR_OFS = 3'h4;
  localparam logic [2:0] RAC_DBG_OFS     = 3'h5;

  // Control register fields
  localparam int         RAC_CTRL_EN_BIT   = 0;
  localparam int         RAC_CTRL_MODE_LSB = 1;
  localparam logic [7:0] RAC_CTRL_RW_MASK  = 8'h07;
  localparam logic [7:0] RAC_CTRL_RST      = 8'h00;

  // Status register fields
  localparam int         RAC_STAT_EN_BIT    = 0;
  localparam int         RAC_STAT_STATE_LSB = 1;
  localparam int         RAC_STAT_BUSY_BIT  = 3;

  // Command register bits, write-only
  localparam int         RAC_CMD_SWRST_BIT = 0;
  localparam int         RAC_CMD_PULSE_BIT = 1;

  // Shared flag state behind the set and clear aliases
  localparam logic [7:0] RAC_FLAGS_RST = 8'h00;

  // Debug control register
  localparam logic [7:0] RAC_DBG_RW_MASK = 8'h03;
  localparam logic [7:0] RAC_DBG_RST     = 8'h00;

  typedef enum logic [1:0] {
    RAC_MODE_IDLE = 2'b00,
    RAC_MODE_RUN  = 2'b01,
    RAC_MODE_HOLD = 2'b10
  } rac_mode_t;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] dbg;
    logic [7:0] flags;
    logic       cmd_pulse;
    logic [7:0] rdata;
  } rac_state_t;

  localparam rac_state_t RAC_STATE_RST = '{
    ctrl:      RAC_CTRL_RST,
    dbg:       RAC_DBG_RST,
    flags:     RAC_FLAGS_RST,
    cmd_pulse: 1'b0,
    rdata:     8'h00
  };

endpackage

// *** tb.sv ***
// Self-checking random and corner-case testbench for the register bank
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin err_total++; \
  $display("Error %s expected %h seen %h", nm, ex, got); end end
module tb;
  localparam logic [2:0] O_CTRL = rac_pkg::RAC_CTRL_OFS;
  localparam logic [2:0] O_STAT = rac_pkg::RAC_STATUS_OFS;
  localparam logic [2:0] O_CMD  = rac_pkg::RAC_CMD_OFS;
  localparam logic [2:0] O_SET  = rac_pkg::RAC_FLAGSET_OFS;
  localparam logic [2:0] O_CLR  = rac_pkg::RAC_FLAGCLR_OFS;
  localparam logic [2:0] O_DBG  = rac_pkg::RAC_DBG_OFS;
  logic       clk_in, rst_b_in, wr0_en_in, wr1_en_in, rd_en_in, busy_in;
  logic [2:0] wr0_addr_in, wr1_addr_in, rd_addr_in;
  logic [7:0] wr0_data_in, wr1_data_in, rdata_out, flags_out, dbg_out;
  logic       enable_out, cmd_pulse_out;
  logic [1:0] mode_out;
  logic [7:0] m_ctrl, m_dbg, m_flags, m_rdata;
  logic       m_pulse, m_rd_ok;
  int         err_total, n_checks;

  rac_regbank DUT (.clk_in(clk_in), .rst_b_in(rst_b_in), .wr0_en_in(wr0_en_in),
    .wr0_addr_in(wr0_addr_in), .wr0_data_in(wr0_data_in), .wr1_en_in(wr1_en_in),
    .wr1_addr_in(wr1_addr_in), .wr1_data_in(wr1_data_in), .rd_en_in(rd_en_in),
    .rd_addr_in(rd_addr_in), .busy_in(busy_in), .rdata_out(rdata_out),
    .enable_out(enable_out), .mode_out(mode_out), .flags_out(flags_out),
    .dbg_out(dbg_out), .cmd_pulse_out(cmd_pulse_out));

  function automatic logic [1:0] mode_dec(input logic [7:0] c);
    return (c[2:1] == 2'h3) ? 2'h0 : c[2:1];
  endfunction

  function automatic logic [7:0] rd_val(input logic [2:0] a, input logic b);
    case (a)
      O_CTRL:        return m_ctrl;
      O_STAT:        return {4'h0, b, mode_dec(m_ctrl), m_ctrl[0]};
      O_SET, O_CLR:  return m_flags;
      O_DBG:         return m_dbg;
      default:       return 8'h00;
    endcase
  endfunction

  // Software side keeps reserved bits and codes out, except in corner cases
  function automatic logic [7:0] rnd_data(input logic [2:0] a);
    logic [7:0] d;
    d = 8'($urandom);
    case (a)
      O_CTRL:       d = {5'h00, 2'($urandom % 3), d[0]};
      O_CMD:        d = {6'h00, d[1], 1'(($urandom % 16) == 0)};
      O_DBG:        d = d & rac_pkg::RAC_DBG_RW_MASK;
      O_SET, O_CLR: d = d;
      default:      d = 8'h00;
    endcase
    return d;
  endfunction

  task automatic apply(input logic [2:0] a, input logic [7:0] d,
                       inout logic [7:0] st, inout logic [7:0] cl,
                       inout logic sr, inout logic pl);
    case (a)
      O_CTRL:  m_ctrl = d & rac_pkg::RAC_CTRL_RW_MASK;
      O_CMD: begin
        sr |= d[0];
        pl |= d[1];
      end
      O_SET:   st |= d;
      O_CLR:   cl |= d;
      O_DBG:   m_dbg = d & rac_pkg::RAC_DBG_RW_MASK;
      default: ;
    endcase
  endtask

  // Port 1 applied first so that port 0 wins on a shared plain register
  task automatic upd();
    logic [7:0] st, cl;
    logic       sr, pl;
    st = 8'h00;
    cl = 8'h00;
    sr = 1'h0;
    pl = 1'h0;
    if (!rst_b_in) begin
      {m_ctrl, m_dbg, m_flags, m_rdata, m_pulse, m_rd_ok} = {33'h0, 1'h1};
      return;
    end
    if (rd_en_in) begin
      m_rd_ok = (rd_addr_in != O_CMD);
      m_rdata = rd_val(rd_addr_in, busy_in);
    end
    if (wr1_en_in) apply(wr1_addr_in, wr1_data_in, st, cl, sr, pl);
    if (wr0_en_in) apply(wr0_addr_in, wr0_data_in, st, cl, sr, pl);
    m_flags = (m_flags | st) & ~cl;
    m_pulse = pl & ~sr;
    if (sr) {m_ctrl, m_flags} = 16'h0000;
  endtask

  task automatic check();
    if (m_rd_ok) `CHK("rdata_out", m_rdata, rdata_out)
    `CHK("enable_out", m_ctrl[0], enable_out)
    `CHK("mode_out", mode_dec(m_ctrl), mode_out)
    `CHK("flags_out", m_flags, flags_out)
    `CHK("dbg_out", m_dbg, dbg_out)
    `CHK("cmd_pulse_out", m_pulse, cmd_pulse_out)
  endtask

  task automatic step(input logic r, input logic w0, input logic [2:0] a0,
                      input logic [7:0] d0, input logic w1, input logic [2:0] a1,
                      input logic [7:0] d1, input logic re, input logic [2:0] ra);
    @(negedge clk_in);
    check();
    {rst_b_in, wr0_en_in, wr0_addr_in, wr0_data_in} = {r, w0, a0, d0};
    {wr1_en_in, wr1_addr_in, wr1_data_in, rd_en_in, rd_addr_in} = {w1, a1, d1, re, ra};
    busy_in = 1'($urandom);
    @(posedge clk_in);
    upd();
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    step(1'h1, 1'h1, a, d, 1'h0, 3'h0, 8'h00, 1'h0, 3'h0);
  endtask

  task automatic rd(input logic [2:0] a);
    step(1'h1, 1'h0, 3'h0, 8'h00, 1'h0, 3'h0, 8'h00, 1'h1, a);
  endtask

  task automatic conclude();
    $display("Checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end

  initial begin
    logic [2:0] a0, a1, ra;
    {rst_b_in, wr0_en_in, wr0_addr_in, wr0_data_in, busy_in} = 14'h0000;
    {wr1_en_in, wr1_addr_in, wr1_data_in, rd_en_in, rd_addr_in} = 16'h0000;
    err_total = 0;
    n_checks = 0;
    void'($urandom(32'h3269e57b));
    @(posedge clk_in);
    upd();
    repeat (19) step(1'h0, 1'h0, 3'h0, 8'h00, 1'h0, 3'h0, 8'h00, 1'h0, 3'h0);
    wr(O_SET, 8'h05);
    rd(O_CLR);
    step(1'h1, 1'h1, O_SET, 8'h01, 1'h1, O_CLR, 8'h01, 1'h1, O_SET);
    rd(O_SET);
    // Reserved bits, reserved code, read-only and unmapped places
    wr(O_CTRL, 8'hff);
    rd(O_CTRL);
    rd(O_STAT);
    wr(O_STAT, 8'hff);
    rd(O_STAT);
    wr(3'h7, 8'hff);
    rd(3'h6);
    rd(O_CMD);
    step(1'h1, 1'h1, O_CTRL, 8'h02, 1'h1, O_CTRL, 8'h05, 1'h1, O_CTRL);
    // Soft reset must spare the debug register
    wr(O_DBG, 8'hff);
    wr(O_SET, 8'hff);
    step(1'h1, 1'h1, O_CMD, 8'h01, 1'h1, O_DBG, 8'h02, 1'h1, O_DBG);
    wr(O_CMD, 8'h02);
    rd(O_DBG);
    repeat (800) begin
      a0 = 3'($urandom);
      a1 = 3'($urandom);
      ra = 3'($urandom);
      step(1'(($urandom % 64) != 0), 1'($urandom), a0, rnd_data(a0), 1'($urandom), a1,
           rnd_data(a1), 1'($urandom), ra);
    end
    rd(O_CTRL);
    // Last step's effects are only visible at the next falling edge
    @(negedge clk_in);
    check();
    conclude();
  end

  initial begin
    repeat (5000) @(posedge clk_in);
    err_total++;
    conclude();
  end
endmodule // tb
